// ### common/tdf_params.svh
// Constants for the telemetry downlink framer
`ifndef TDF_PARAMS_SVH
`define TDF_PARAMS_SVH
`define TDF_WORD_BITS 40
`define TDF_REG_BITS 16
`define TDF_DATA_BITS 15
`define TDF_FILL_BITS 7
`define TDF_SER_CNT_W 6
`define TDF_WORD_BITS_CNT 6'd40
`define TDF_FIFO_DEPTH 8
`define TDF_LIST_WORDS 7'd100
`define TDF_FIRST_WORD 7'd1
`define TDF_MID_WORD 7'd51
`define TDF_SNAP1_FIRST 7'd2
`define TDF_SNAP1_LAST 7'd13
`define TDF_SNAP2_FIRST 7'd52
`define TDF_SNAP2_LAST 7'd63
`define TDF_SNAP_REGS 24
`define TDF_SNAP_LAST_IDX 5'd23
`define TDF_CNT_FIRST 7'd35
`define TDF_FLAG_FIRST 7'd40
`define TDF_DISP_FIRST 7'd45
`define TDF_LIST2_FIRST 7'd64
`define TDF_IOF_FIRST 7'd85
`define TDF_DISP2_FIRST 7'd95
`define TDF_ID_POWERED 15'h7FFC
`define TDF_ID_COAST 15'h7FFF
`define TDF_ID_RNDZ 15'h7FFD
`define TDF_ID_BACKUP 15'h7FFE
`define TDF_ID_DUMP 15'h7FF0
`define TDF_SYNC_DATA 15'h7EE0
`define TDF_CLK_HZ 25000000
`define TDF_WORD_RATE_WPS 50
`define TDF_WORD_PERIOD_CYC (`TDF_CLK_HZ / `TDF_WORD_RATE_WPS)
`define TDF_LATE_CYC (2 * `TDF_WORD_PERIOD_CYC)
`endif

// ### common/tdf_pkg.sv
// Types for the telemetry downlink framer
package tdf_pkg;
	typedef enum logic [2:0] {
		TDF_LIST_POWERED, TDF_LIST_COAST, TDF_LIST_RNDZ, TDF_LIST_BACKUP, TDF_LIST_DUMP
	} tdf_list_t;
	typedef enum logic [2:0] {
		TDF_REG_HEAD, TDF_REG_SNAPSHOT, TDF_REG_LIST_DATA, TDF_REG_COUNTERS,
		TDF_REG_FLAGS, TDF_REG_DISPLAY, TDF_REG_IO_FLAGS, TDF_REG_MIDPOINT
	} tdf_region_t;
	typedef enum logic [2:0] {
		TDF_ST_IDLE, TDF_ST_CAP_RD, TDF_ST_CAP_WR, TDF_ST_RD_A, TDF_ST_RD_B, TDF_ST_WR_B,
		TDF_ST_PUSH
	} tdf_state_t;
endpackage

// ### rtl/tdf_fifo.sv
// Word FIFO between framing and serial output
`timescale 1ns/10ps
module tdf_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
	logic push, pop, full, empty;

	always_comb begin
		full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
		empty = (wr_reg == rd_reg);
		push = in_valid_i && !full;
		pop = out_ready_i && !empty;
		wr_next = push ? wr_reg + 1'b1 : wr_reg;
		rd_next = pop ? rd_reg + 1'b1 : rd_reg;
	end

	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem_reg[rd_reg[AW-1:0]];

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem_reg[wr_reg[AW-1:0]] <= in_data_i;
		end
	end

	a_fifo_no_overrun: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		full && !pop |=> $stable(wr_reg)) else $error("fifo pointer moved while full");
endmodule

// ### rtl/tdf_framer.sv
// Telemetry downlink framer: list sequencing, word build and serial output
`timescale 1ns/10ps
`include "tdf_params.svh"
// Operation
// [RULE_01] Word-done pulse loads next two registers
// [RULE_02] Words are 33 bits plus seven fillers
// [RULE_03] Order bit, first register, second register
// [RULE_04] Register field: 15 data, odd parity
// [RULE_05] Fillers repeat first seven register bits
// [RULE_06] Word one: identifier, sync, order zero
// [RULE_07] Order bit one, except midpoint word 51
// [RULE_08] Identifiers negative, elapsed time pair positive; code forces only the first time register's sign bit to zero
// [RULE_09] Distinct identifier codes per list
// [RULE_10] Sync register holds fixed pattern
// [RULE_11] Hundred words per list, fifty per second
// [RULE_12] List chosen only at pass start
// [RULE_13] Programs request list through identifier register
// [RULE_14] Dump passes finish despite other requests
// [RULE_15] Words 2-13 sent from snapshot
// [RULE_16] Words 52-63 sent from snapshot
// [RULE_17] Other words read live at sending
// [RULE_18] Fixed layout regions within the list
// [RULE_19] Identifier marks start and names layout
// [RULE_20] Telemetry programmer paces serial flow
// [RULE_21] Fields sent most significant bit first
module tdf_framer #(
	parameter int FIFO_DEPTH = `TDF_FIFO_DEPTH,
	parameter int LATE_CYC = `TDF_LATE_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic word_done_i,
	input wire logic [14:0] list_req_i,
	input wire logic dump_req_i,
	input wire logic [7:0] dump_passes_i,
	input wire logic [29:0] elapsed_time_pair_i,
	output logic src_rd_o,
	output tdf_pkg::tdf_list_t src_list_o,
	output logic [7:0] src_index_o,
	input wire logic [14:0] src_data_i,
	input wire logic ser_shift_i,
	output logic ser_data_o,
	output logic [15:0] chan_first_o,
	output logic [15:0] chan_second_o,
	output logic order_bit_o,
	output logic word_loaded_o,
	output logic [6:0] word_num_o,
	output tdf_pkg::tdf_region_t region_o,
	output tdf_pkg::tdf_list_t list_o,
	output logic word_late_o
);
	tdf_pkg::tdf_state_t state_reg, state_next;
	tdf_pkg::tdf_list_t list_reg, list_next, req_list;
	tdf_pkg::tdf_region_t region_reg, region_next, cur_region;
	logic [6:0] word_reg, word_next, snap_first, word_num_reg, word_num_next;
	logic [14:0] fa_reg, fa_next, fb_reg, fb_next, snap_reg [`TDF_SNAP_REGS];
	logic [4:0] cap_reg, cap_next, snap_off;
	logic [7:0] dump_left_reg, dump_left_next, dump_n_reg, dump_n_next;
	logic dump_pend_reg, dump_pend_next, pend_reg, pend_next, go, consume, pass_start;
	logic req_ok, in_snap, snap_we, push_valid, push_ready, pop_valid, pop_ready;
	logic [15:0] field_a, field_b;
	logic [39:0] push_word, pop_word;

	function automatic logic [15:0] tdf_field(input logic [14:0] d);
		return {d, ~^d};
	endfunction

	function automatic logic [14:0] tdf_id_of(input tdf_pkg::tdf_list_t l);
		case (l)
			tdf_pkg::TDF_LIST_POWERED: return `TDF_ID_POWERED;
			tdf_pkg::TDF_LIST_COAST: return `TDF_ID_COAST;
			tdf_pkg::TDF_LIST_RNDZ: return `TDF_ID_RNDZ;
			tdf_pkg::TDF_LIST_BACKUP: return `TDF_ID_BACKUP;
			default: return `TDF_ID_DUMP;
		endcase
	endfunction

	// [RULE_09] identifier decode
	// [RULE_13] request taken from identifier input
	always_comb begin
		req_ok = 1'b1;
		case (list_req_i)
			`TDF_ID_POWERED: req_list = tdf_pkg::TDF_LIST_POWERED;
			`TDF_ID_COAST: req_list = tdf_pkg::TDF_LIST_COAST;
			`TDF_ID_RNDZ: req_list = tdf_pkg::TDF_LIST_RNDZ;
			`TDF_ID_BACKUP: req_list = tdf_pkg::TDF_LIST_BACKUP;
			default: begin
				req_list = list_reg;
				req_ok = 1'b0;
			end
		endcase
	end

	// [RULE_18] layout regions of the list
	always_comb begin
		if (word_reg == `TDF_FIRST_WORD) begin
			cur_region = tdf_pkg::TDF_REG_HEAD;
		end else if (word_reg == `TDF_MID_WORD) begin
			cur_region = tdf_pkg::TDF_REG_MIDPOINT;
		end else if (word_reg >= `TDF_DISP2_FIRST) begin
			cur_region = tdf_pkg::TDF_REG_DISPLAY;
		end else if (word_reg >= `TDF_IOF_FIRST) begin
			cur_region = tdf_pkg::TDF_REG_IO_FLAGS;
		end else if (word_reg >= `TDF_LIST2_FIRST) begin
			cur_region = tdf_pkg::TDF_REG_LIST_DATA;
		end else if (word_reg >= `TDF_SNAP2_FIRST) begin
			cur_region = tdf_pkg::TDF_REG_SNAPSHOT;
		end else if (word_reg >= `TDF_DISP_FIRST) begin
			cur_region = tdf_pkg::TDF_REG_DISPLAY;
		end else if (word_reg >= `TDF_FLAG_FIRST) begin
			cur_region = tdf_pkg::TDF_REG_FLAGS;
		end else if (word_reg >= `TDF_CNT_FIRST) begin
			cur_region = tdf_pkg::TDF_REG_COUNTERS;
		end else if (word_reg > `TDF_SNAP1_LAST) begin
			cur_region = tdf_pkg::TDF_REG_LIST_DATA;
		end else begin
			cur_region = tdf_pkg::TDF_REG_SNAPSHOT;
		end
	end

	// Word build, most significant bit first
	// [RULE_02] [RULE_03] [RULE_04] [RULE_05] [RULE_21] word layout
	always_comb begin
		field_a = tdf_field(fa_reg);
		field_b = tdf_field(fb_reg);
		// [RULE_06] [RULE_07] order bit
		push_word = {(word_reg != `TDF_FIRST_WORD) && (word_reg != `TDF_MID_WORD),
			field_a, field_b, field_a[15:9]};
	end

	always_comb begin
		go = word_done_i || pend_reg;
		consume = (state_reg == tdf_pkg::TDF_ST_IDLE) && go;
		pass_start = consume && (word_reg == `TDF_FIRST_WORD);
		snap_first = (word_reg > `TDF_MID_WORD) ? `TDF_SNAP2_FIRST : `TDF_SNAP1_FIRST;
		snap_off = 5'((word_reg - snap_first) << 1);
		in_snap = ((word_reg > `TDF_SNAP1_FIRST) && (word_reg <= `TDF_SNAP1_LAST))
			|| ((word_reg > `TDF_SNAP2_FIRST) && (word_reg <= `TDF_SNAP2_LAST));
		state_next = state_reg;
		list_next = list_reg;
		word_next = word_reg;
		fa_next = fa_reg;
		fb_next = fb_reg;
		cap_next = cap_reg;
		region_next = region_reg;
		word_num_next = word_num_reg;
		dump_left_next = dump_left_reg;
		dump_n_next = dump_n_reg;
		dump_pend_next = dump_pend_reg;
		snap_we = 1'b0;
		src_rd_o = 1'b0;
		src_index_o = 8'((word_reg - 7'd1) << 1);
		push_valid = 1'b0;
		// Late word-done is held, not lost
		pend_next = (pend_reg && !consume) || (word_done_i && !(consume && !pend_reg));
		// Dump request pulse wins over its clear
		if (dump_req_i) begin
			dump_pend_next = 1'b1;
			dump_n_next = dump_passes_i;
		end
		case (state_reg)
			tdf_pkg::TDF_ST_IDLE: begin
				if (consume) begin
					// [RULE_01] word-done starts the next word
					state_next = tdf_pkg::TDF_ST_RD_A;
					if (pass_start) begin
						// [RULE_12] list switched only here
						// [RULE_14] dump passes ignore list requests
						if (dump_left_reg != 8'h00) begin
							list_next = tdf_pkg::TDF_LIST_DUMP;
							dump_left_next = dump_left_reg - 8'h01;
						end else if (dump_pend_reg && dump_n_reg != 8'h00) begin
							list_next = tdf_pkg::TDF_LIST_DUMP;
							dump_left_next = dump_req_i ? dump_passes_i - 8'h01
								: dump_n_reg - 8'h01;
							dump_pend_next = dump_req_i;
						end else if (req_ok) begin
							list_next = req_list;
						end
						// [RULE_19] identifier heads the list
						// [RULE_08] identifiers carry the sign bit
						fa_next = tdf_id_of(list_next);
						// [RULE_10] fixed sync pattern
						fb_next = `TDF_SYNC_DATA;
						state_next = tdf_pkg::TDF_ST_PUSH;
					end else if (word_reg == `TDF_MID_WORD) begin
						// [RULE_08] first time register forced positive, second keeps input bit 14 as its sign
						fa_next = {1'b0, elapsed_time_pair_i[28:15]};
						fb_next = elapsed_time_pair_i[14:0];
						state_next = tdf_pkg::TDF_ST_PUSH;
					end else if (word_reg == `TDF_SNAP1_FIRST || word_reg == `TDF_SNAP2_FIRST) begin
						cap_next = 5'h00;
						state_next = tdf_pkg::TDF_ST_CAP_RD;
					end else if (in_snap) begin
						fa_next = snap_reg[snap_off];
						fb_next = snap_reg[snap_off + 5'h01];
						state_next = tdf_pkg::TDF_ST_PUSH;
					end
				end
			end
			tdf_pkg::TDF_ST_CAP_RD: begin
				// [RULE_15] [RULE_16] snapshot copy at first word
				src_rd_o = 1'b1;
				src_index_o = 8'((word_reg - 7'd1) << 1) + 8'(cap_reg);
				state_next = tdf_pkg::TDF_ST_CAP_WR;
			end
			tdf_pkg::TDF_ST_CAP_WR: begin
				snap_we = 1'b1;
				cap_next = cap_reg + 5'h01;
				state_next = tdf_pkg::TDF_ST_CAP_RD;
				if (cap_reg == `TDF_SNAP_LAST_IDX) begin
					fa_next = snap_reg[0];
					fb_next = snap_reg[1];
					state_next = tdf_pkg::TDF_ST_PUSH;
				end
			end
			tdf_pkg::TDF_ST_RD_A: begin
				// [RULE_17] live read at sending time
				src_rd_o = 1'b1;
				state_next = tdf_pkg::TDF_ST_RD_B;
			end
			tdf_pkg::TDF_ST_RD_B: begin
				src_rd_o = 1'b1;
				src_index_o = 8'((word_reg - 7'd1) << 1) + 8'h01;
				fa_next = src_data_i;
				state_next = tdf_pkg::TDF_ST_WR_B;
			end
			tdf_pkg::TDF_ST_WR_B: begin
				fb_next = src_data_i;
				state_next = tdf_pkg::TDF_ST_PUSH;
			end
			tdf_pkg::TDF_ST_PUSH: begin
				push_valid = 1'b1;
				if (push_ready) begin
					// [RULE_11] hundred-word list wraps
					word_next = (word_reg == `TDF_LIST_WORDS) ? `TDF_FIRST_WORD
						: word_reg + 7'd1;
					word_num_next = word_reg;
					region_next = cur_region;
					state_next = tdf_pkg::TDF_ST_IDLE;
				end
			end
			default: state_next = tdf_pkg::TDF_ST_IDLE;
		endcase
	end

	assign src_list_o = list_reg;
	assign list_o = list_reg;
	assign word_num_o = word_num_reg;
	assign region_o = region_reg;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= tdf_pkg::TDF_ST_IDLE;
			list_reg <= tdf_pkg::TDF_LIST_POWERED;
			word_reg <= `TDF_FIRST_WORD;
			fa_reg <= 15'h0000;
			fb_reg <= 15'h0000;
			cap_reg <= 5'h00;
			region_reg <= tdf_pkg::TDF_REG_HEAD;
			word_num_reg <= 7'h00;
			dump_left_reg <= 8'h00;
			dump_n_reg <= 8'h00;
			dump_pend_reg <= 1'b0;
			pend_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			list_reg <= list_next;
			word_reg <= word_next;
			fa_reg <= fa_next;
			fb_reg <= fb_next;
			cap_reg <= cap_next;
			region_reg <= region_next;
			word_num_reg <= word_num_next;
			dump_left_reg <= dump_left_next;
			dump_n_reg <= dump_n_next;
			dump_pend_reg <= dump_pend_next;
			pend_reg <= pend_next;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (snap_we) begin
			snap_reg[cap_reg] <= src_data_i;
		end
	end

	tdf_fifo #(.WIDTH(`TDF_WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.in_valid_i(push_valid),
		.in_ready_o(push_ready),
		.in_data_i(push_word),
		.out_valid_o(pop_valid),
		.out_ready_i(pop_ready),
		.out_data_o(pop_word)
	);

	// Serial output and output channels
	logic [39:0] sh_reg, sh_next;
	logic [5:0] bits_reg, bits_next;
	logic [15:0] cha_reg, cha_next, chb_reg, chb_next;
	logic ord_reg, ord_next, ld_reg, ld_next;
	logic [21:0] gap_reg, gap_next;
	logic late_reg, late_next;

	always_comb begin
		pop_ready = (bits_reg == 6'h00);
		sh_next = sh_reg;
		bits_next = bits_reg;
		cha_next = cha_reg;
		chb_next = chb_reg;
		ord_next = ord_reg;
		ld_next = 1'b0;
		if (pop_ready && pop_valid) begin
			sh_next = pop_word;
			bits_next = `TDF_WORD_BITS_CNT;
			ord_next = pop_word[39];
			cha_next = pop_word[38:23];
			chb_next = pop_word[22:7];
			ld_next = 1'b1;
		end else if (ser_shift_i && bits_reg != 6'h00) begin
			// [RULE_20] shift only on programmer strobe
			sh_next = {sh_reg[38:0], 1'b0};
			bits_next = bits_reg - 6'h01;
		end
		// [RULE_11] word-done spacing watchdog
		gap_next = word_done_i ? 22'h000000 : gap_reg;
		late_next = late_reg && !word_done_i;
		if (!word_done_i && gap_reg != 22'(LATE_CYC)) begin
			gap_next = gap_reg + 22'h000001;
		end else if (!word_done_i) begin
			late_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sh_reg <= 40'h0000000000;
			bits_reg <= 6'h00;
			cha_reg <= 16'h0000;
			chb_reg <= 16'h0000;
			ord_reg <= 1'b0;
			ld_reg <= 1'b0;
			gap_reg <= 22'h000000;
			late_reg <= 1'b0;
		end else begin
			sh_reg <= sh_next;
			bits_reg <= bits_next;
			cha_reg <= cha_next;
			chb_reg <= chb_next;
			ord_reg <= ord_next;
			ld_reg <= ld_next;
			gap_reg <= gap_next;
			late_reg <= late_next;
		end
	end

	assign ser_data_o = sh_reg[39];
	assign chan_first_o = cha_reg;
	assign chan_second_o = chb_reg;
	assign order_bit_o = ord_reg;
	assign word_loaded_o = ld_reg;
	assign word_late_o = late_reg;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	a_word_start: assert property (word_done_i && state_reg == tdf_pkg::TDF_ST_IDLE && !pend_reg
		|-> ##[1:60] push_valid) else $error("word not built after word-done"); // [RULE_01]
	a_word_bits: assert property (ld_reg |-> bits_reg == 6'd40 && sh_reg[6:0] == sh_reg[38:32])
		else $error("serial word not 40 bits with fillers"); // [RULE_02]
	a_field_parity: assert property (push_valid |-> ^push_word[38:23] && ^push_word[22:7])
		else $error("register field parity not odd"); // [RULE_04]
	a_filler_copy: assert property (push_valid |-> push_word[6:0] == push_word[38:32])
		else $error("filler bits differ from first register"); // [RULE_05]
	a_head_word: assert property (push_valid && word_reg == 7'd1
		|-> !push_word[39] && push_word[22:8] == 15'h7EE0 && push_word[38])
		else $error("first word wrong"); // [RULE_06]
	a_mid_order: assert property (push_valid |-> push_word[39] == (word_reg != 7'd1
		&& word_reg != 7'd51)) else $error("order bit wrong"); // [RULE_07]
	a_time_positive: assert property (push_valid && word_reg == 7'd51 |-> !push_word[38])
		else $error("time pair negative"); // [RULE_08]
	a_list_hold: assert property (!pass_start |=> $stable(list_reg))
		else $error("list changed mid pass"); // [RULE_12]
	a_dump_hold: assert property (pass_start && dump_left_reg != 8'h00
		|=> list_reg == tdf_pkg::TDF_LIST_DUMP) else $error("dump pass cut short"); // [RULE_14]
	a_snap_no_live: assert property (src_rd_o && in_snap |-> state_reg != tdf_pkg::TDF_ST_RD_A
		&& state_reg != tdf_pkg::TDF_ST_RD_B) else $error("snapshot word read live"); // [RULE_15]
	// Capture alternates read and write, so only the first read starts the count
	a_snap_len: assert property ($rose(state_reg == tdf_pkg::TDF_ST_CAP_RD) && cap_reg == 5'h00
		|-> ##48 state_reg == tdf_pkg::TDF_ST_PUSH) else $error("snapshot size wrong"); // [RULE_16]
	a_list_wrap: assert property (push_valid && push_ready && word_reg == 7'd100
		|=> word_reg == 7'd1) else $error("list not 100 words"); // [RULE_11]

	c_snapshot: cover property (state_reg == tdf_pkg::TDF_ST_CAP_WR && cap_reg == 5'd23);
	c_midpoint: cover property (push_valid && push_ready && word_reg == 7'd51);
	c_list_change: cover property (pass_start ##1 $changed(list_reg));
	c_dump_pass: cover property (pass_start && dump_left_reg != 8'h00);
endmodule

// ### verif/tb.sv
// Self-checking bench for the telemetry downlink framer
`timescale 1ns/10ps
`include "tdf_params.svh"
module tb;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic word_done_i = 1'b0;
	logic dump_req_i = 1'b0;
	logic [14:0] list_req_i = 15'h7FFC;
	logic [14:0] src_data_i = 15'h0000;
	logic [7:0] dump_passes_i = 8'h00;
	logic [29:0] elapsed_time_pair_i = 30'h00000000;
	logic stall = 1'b0;
	logic hold = 1'b0;
	logic rand_on = 1'b0;
	logic src_rd_o, ser_shift_i, ser_data_o, order_bit_o, word_loaded_o, word_late_o, wvalid;
	tdf_pkg::tdf_list_t src_list_o, list_o;
	tdf_pkg::tdf_list_t cur = tdf_pkg::TDF_LIST_POWERED;
	tdf_pkg::tdf_region_t region_o;
	logic [7:0] src_index_o;
	logic [15:0] chan_first_o, chan_second_o;
	logic [6:0] word_num_o;
	logic [6:0] wnum = 7'd1;
	logic [39:0] wcap;
	logic [40:0] exp_q[$];
	logic [40:0] ser_q[$];
	logic [31:0] lfsr = 32'hEF3726B4;
	logic [31:0] rnd = 32'hEF3726B4;
	logic [3:0] gen = 4'h0;
	logic [3:0] g2 = 4'h0;
	logic [3:0] g52 = 4'h0;
	logic [14:0] req = 15'h7FFC;
	int dleft = 0;
	int error_cnt = 0;
	int checks = 0;

	initial begin
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	tdf_framer #(.FIFO_DEPTH(8), .LATE_CYC(200)) i_tdf_framer (
		.ref_clk_i, .rst_i, .word_done_i, .list_req_i, .dump_req_i, .dump_passes_i,
		.elapsed_time_pair_i, .src_rd_o, .src_list_o, .src_index_o, .src_data_i,
		.ser_shift_i, .ser_data_o, .chan_first_o, .chan_second_o, .order_bit_o,
		.word_loaded_o, .word_num_o, .region_o, .list_o, .word_late_o
	);
	tdf_tlm_model i_tdf_tlm_model (.ref_clk_i, .rst_i, .stall_i(stall),
		.word_loaded_i(word_loaded_o), .ser_data_i(ser_data_o), .ser_shift_o(ser_shift_i),
		.word_o(wcap), .word_valid_o(wvalid));

	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction
	function automatic logic [39:0] mk(input logic o, input logic [14:0] a, input logic [14:0] b);
		return {o, a, ~^a, b, ~^b, a[14:8]};
	endfunction
	function automatic logic [14:0] id_of(input tdf_pkg::tdf_list_t l);
		case (l)
			tdf_pkg::TDF_LIST_COAST: return `TDF_ID_COAST;
			tdf_pkg::TDF_LIST_RNDZ: return `TDF_ID_RNDZ;
			tdf_pkg::TDF_LIST_BACKUP: return `TDF_ID_BACKUP;
			tdf_pkg::TDF_LIST_DUMP: return `TDF_ID_DUMP;
			default: return `TDF_ID_POWERED;
		endcase
	endfunction
	function automatic tdf_pkg::tdf_region_t reg_of(input logic [6:0] w);
		if (w == 7'd1) return tdf_pkg::TDF_REG_HEAD;
		if (w == 7'd51) return tdf_pkg::TDF_REG_MIDPOINT;
		if ((w >= 7'd2 && w <= 7'd13) || (w >= 7'd52 && w <= 7'd63)) return tdf_pkg::TDF_REG_SNAPSHOT;
		if (w >= 7'd95 || (w >= 7'd45 && w <= 7'd50)) return tdf_pkg::TDF_REG_DISPLAY;
		if (w >= 7'd85) return tdf_pkg::TDF_REG_IO_FLAGS;
		if (w >= 7'd40 && w <= 7'd44) return tdf_pkg::TDF_REG_FLAGS;
		if (w >= 7'd35 && w <= 7'd39) return tdf_pkg::TDF_REG_COUNTERS;
		return tdf_pkg::TDF_REG_LIST_DATA;
	endfunction

	task automatic cmp(input string n, input logic [39:0] e, input logic [39:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic results();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// One word-done pulse, expected word noted
	task automatic frame(input int gap, input logic chk);
		logic [3:0] g;
		logic [7:0] ix;
		logic [40:0] e;
		@(posedge ref_clk_i);
		lfsr = nxt(lfsr);
		g = gen + 4'h1;
		gen <= g;
		word_done_i <= 1'b1;
		elapsed_time_pair_i <= lfsr[29:0];
		if (wnum == 7'd1 && dleft != 0) begin
			cur = tdf_pkg::TDF_LIST_DUMP;
			dleft--;
		end else if (wnum == 7'd1) begin
			case (req)
				`TDF_ID_POWERED: cur = tdf_pkg::TDF_LIST_POWERED;
				`TDF_ID_COAST: cur = tdf_pkg::TDF_LIST_COAST;
				`TDF_ID_RNDZ: cur = tdf_pkg::TDF_LIST_RNDZ;
				`TDF_ID_BACKUP: cur = tdf_pkg::TDF_LIST_BACKUP;
				default: ;
			endcase
		end
		if (wnum == 7'd2) g2 = g;
		if (wnum == 7'd52) g52 = g;
		if (wnum > 7'd2 && wnum <= 7'd13) g = g2;
		if (wnum > 7'd52 && wnum <= 7'd63) g = g52;
		ix = {wnum - 7'd1, 1'b0};
		if (wnum == 7'd1) e = {1'b0, mk(1'b0, id_of(cur), `TDF_SYNC_DATA)};
		else if (wnum == 7'd51 && cur != tdf_pkg::TDF_LIST_DUMP)
			e = {1'b0, mk(1'b0, {1'b0, lfsr[28:15]}, lfsr[14:0])};
		else e = {cur == tdf_pkg::TDF_LIST_DUMP, mk(1'b1, {g, cur, ix}, {g, cur, ix + 8'h01})};
		exp_q.push_back(e);
		@(posedge ref_clk_i);
		word_done_i <= 1'b0;
		repeat (gap) @(posedge ref_clk_i);
		if (chk && cur != tdf_pkg::TDF_LIST_DUMP) begin
			cmp("word number", 40'(wnum), 40'(word_num_o)); // Count
			cmp("region", 40'(reg_of(wnum)), 40'(region_o)); // Layout
			cmp("active list", 40'(cur), 40'(list_o)); // List
		end
		wnum = (wnum == `TDF_LIST_WORDS) ? 7'd1 : wnum + 7'd1;
	endtask

	// Source registers answer one cycle after each read
	always @(posedge ref_clk_i) begin
		if (src_rd_o === 1'b1) src_data_i <= {gen, src_list_o, src_index_o};
		else src_data_i <= ~src_data_i;
	end

	always @(posedge ref_clk_i) begin
		rnd = nxt(rnd);
		stall <= hold | (rand_on & (rnd[3:0] == 4'h0));
	end

	always @(posedge ref_clk_i) begin
		logic [40:0] e;
		if (wvalid === 1'b1) begin
			e = ser_q.pop_front();
			if (!e[40]) cmp("serial word", e[39:0], wcap); // Wire
		end
		if (word_loaded_o === 1'b1 && exp_q.size() == 0) begin
			cmp("unexpected word", 40'h0, 40'h1);
		end else if (word_loaded_o === 1'b1) begin
			e = exp_q.pop_front();
			ser_q.push_back(e);
			if (!e[40]) begin
				cmp("first channel", 40'(e[38:23]), 40'(chan_first_o)); // Load
				cmp("second channel", 40'(e[22:7]), 40'(chan_second_o)); // Load
				cmp("order bit", 40'(e[39]), 40'(order_bit_o)); // Order
			end
		end
	end

	initial begin
		logic [14:0] tbl[5] = '{15'h7FFF, 15'h7FF1, 15'h7FFD, 15'h7FFE, 15'h7FFC};
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		for (int p = 0; p < 7; p++) begin
			rand_on <= (p != 0);
			for (int k = 1; k <= 100; k++) begin
				if (k == 30 && p < 5) begin
					req = tbl[p];
					list_req_i <= tbl[p];
				end
				if (p == 4 && k == 40) begin
					dump_req_i <= 1'b1;
					dump_passes_i <= 8'h02;
					dleft = 2;
					@(posedge ref_clk_i);
					dump_req_i <= 1'b0;
				end
				if (p == 0 && k == 20) begin
					repeat (220) @(posedge ref_clk_i);
					cmp("late flag", 40'h1, 40'(word_late_o)); // Pace
				end
				hold <= (p == 0 && k >= 60 && k < 70);
				frame((p == 0 && k >= 60 && k < 70) ? 60 : 95, !(p == 0 && k >= 60 && k < 80));
				if (p == 0 && k == 69) cmp("held word", 40'd68, 40'(word_num_o)); // Full
				if (p == 0 && k == 20) cmp("late flag", 40'h0, 40'(word_late_o)); // Pace
			end
		end
		frame(95, 1'b1);
		for (int t = 0; t < 5000 && exp_q.size() + ser_q.size() != 0; t++) @(posedge ref_clk_i);
		if (exp_q.size() + ser_q.size() != 0) cmp("drain", 40'h0, 40'h1);
		results();
	end
endmodule

// ### verif/tdf_tlm_model.sv
// Telemetry output register model: shifts framed words out bit by bit
`timescale 1ns/10ps
module tdf_tlm_model (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic stall_i,
	input wire logic word_loaded_i,
	input wire logic ser_data_i,
	output logic ser_shift_o,
	output logic [39:0] word_o,
	output logic word_valid_o
);
	logic [5:0] cnt_reg;
	logic [39:0] sh_reg;
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg <= 6'h00;
			sh_reg <= 40'h0000000000;
			ser_shift_o <= 1'b0;
			word_o <= 40'h0000000000;
			word_valid_o <= 1'b0;
		end else begin
			ser_shift_o <= 1'b0;
			word_valid_o <= 1'b0;
			if (word_loaded_i) begin
				cnt_reg <= 6'h28;
			end else if (cnt_reg != 6'h00 && !ser_shift_o && !stall_i) begin
				sh_reg <= {sh_reg[38:0], ser_data_i};
				ser_shift_o <= 1'b1;
				cnt_reg <= cnt_reg - 6'h01;
				if (cnt_reg == 6'h01) begin
					word_valid_o <= 1'b1;
					word_o <= {sh_reg[38:0], ser_data_i};
				end
			end
		end
	end
endmodule
